// File: inc/lcj_pkg.sv
// Purpose: shared constants and types of the limit comparator and range judge
// Assumes: one 250 MHz clock, AHB-Lite register access with 32-bit words
// Notes: impedance in milliohm, values and limits signed integers, percentages in 0.01 % steps
package lcj_pkg;
  localparam int CLK_MHZ = 250;
  localparam int RANGE_SETTLE_NS = 2000;
  localparam int RANGE_SETTLE_CYC = (RANGE_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int DW = 32;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RANGE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_REPORT0 = 8'h0C;
  localparam logic [7:0] REG_REPORT1 = 8'h10;
  localparam logic [7:0] REG_CH0_CFG = 8'h14;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] CH_SPAN = 8'h20;

  // field positions
  localparam int CTRL_COMP = 0;
  localparam int CTRL_SORT = 1;
  localparam int CTRL_INT = 2;
  localparam int CTRL_CH0 = 3;
  localparam int CFG_MODE = 0;
  localparam int CFG_HIOFF = 2;
  localparam int CFG_LOOFF = 3;
  localparam int RNG_ACT = 4;
  localparam int STAT_OVER = 0;
  localparam int STAT_UNDER = 1;
  localparam int STAT_ACC = 2;
  localparam int STAT_V0 = 3;
  localparam int STAT_V1 = 6;
  localparam int STAT_BUSY = 9;

  // value limits
  localparam int VAL_MAX = 200000000;
  localparam int PCT_MAX = 99999;
  localparam int PCT_SCALE = 10000;

  // range bounds in milliohm: accuracy spans and over/under flag bounds
  localparam logic [31:0] ACC_LO_1K = 32'h0000_0064;
  localparam logic [31:0] ACC_HI_1K = 32'h001E_8480;
  localparam logic [31:0] ACC_LO_10K = 32'h000F_4240;
  localparam logic [31:0] ACC_HI_10K = 32'h0131_2D00;
  localparam logic [31:0] ACC_LO_100K = 32'h0098_9680;
  localparam logic [31:0] ACC_HI_100K = 32'h11E1_A300;
  localparam logic [31:0] FLG_LO_1K = 32'h0000_000A;
  localparam logic [31:0] FLG_HI_1K = 32'h002D_C6C0;
  localparam logic [31:0] FLG_LO_10K = 32'h0001_86A0;
  localparam logic [31:0] FLG_HI_10K = 32'h01C9_C380;
  localparam logic [31:0] FLG_LO_100K = 32'h000F_4240;
  localparam logic [31:0] FLG_HI_100K = 32'h1AD2_7480;

  localparam logic [31:0] CTRL_RST = 32'h0000_001C;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SETTLE = 2'b01, ST_CALC = 2'b11, ST_OUT = 2'b10} lcj_state_t;
  typedef enum logic [1:0] {LM_FIXED = 2'b00, LM_PCT = 2'b01, LM_DEV = 2'b10} lcj_lmode_t;
  typedef enum logic [2:0] {RS_AUTO = 3'h0, RS_HOLD = 3'h1, RS_1K = 3'h2, RS_10K = 3'h3, RS_100K = 3'h4} lcj_rsel_t;
  localparam logic [1:0] R_1K = 2'h0;
  localparam logic [1:0] R_10K = 2'h1;
  localparam logic [1:0] R_100K = 2'h2;
  localparam logic [2:0] V_OVER = 3'h4;
  localparam logic [2:0] V_PASS = 3'h2;
  localparam logic [2:0] V_UNDER = 3'h1;
endpackage

// File: design/lcj_range_judge.sv
// Purpose: range selection, range and accuracy flags, two-channel limit verdicts on the rear control port
// Assumes: measurement engine on clk; extTrigN is an asynchronous pin; AHB-Lite single word transfers
// Notes: every bus transfer takes one wait state so that hrdata comes from a flop

// Function
// RQ1: auto mode picks best range for impedance
// RQ2: fixed mode holds range; direct pick fixes
// RQ3: flag above or below active range bounds
// RQ4: warn when outside accuracy span or unstable
// RQ5: each verdict is over, pass or under
// RQ6: range flags force over or under verdict
// RQ7: failed lower check gives under verdict
// RQ8: failed upper check gives over verdict
// RQ9: pass only when both checks succeed
// RQ10: swapped limits are not checked or flagged; the code judges them as set
// RQ11: two channels, each with own limit mode
// RQ12: absolute limits, values clamp to 200M
// RQ13: percent threshold is nominal plus scaled magnitude
// RQ14: percentage limits span plus minus 999.99
// RQ15: upper limit off removes upper check
// RQ16: deviation percent computed, reported and judged
// RQ17: deviation saturates at plus minus 999.99
// RQ18: comparator and sorting never both active
// RQ19: internal trigger starts on entry; port verdicts
// RQ20: accuracy spans per range as specified
// RQ21: range change adds settle delay before result; the code adds it only on auto range switches
// RQ22: priority: range flags, lower, upper, pass
// RQ23: lower limit off removes lower check
module lcj_range_judge #(
  parameter int unsigned SETTLE_CYC = lcj_pkg::RANGE_SETTLE_CYC
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [lcj_pkg::DW-1:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [lcj_pkg::DW-1:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic measValid, // result strobe
  input wire logic [31:0] measImp, // impedance, milliohm
  input wire logic [31:0] measVal0, // first parameter value
  input wire logic [31:0] measVal1, // second parameter value
  input wire logic measUnstable, // engine saw unstable system
  input wire logic extTrigN, // rear port trigger, low pulse
  output logic measStart, // start one measurement
  output logic [1:0] rangeSel, // active range to engine
  output logic rangeChanged, // auto range switched this cycle
  output logic sortActive, // sorting function enabled
  output logic [1:0] portOver, // over_maximum_verdict per channel
  output logic [1:0] portPass, // pass verdict per channel
  output logic [1:0] portUnder, // under_minimum_verdict per channel
  output logic portEnd, // verdict update strobe
  output logic portAccWarn // reference-only result
);
  import lcj_pkg::*;

  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_chk
    $error("SETTLE_CYC out of range");
  end

  typedef struct packed {
    lcj_state_t st;
    logic compEn;
    logic sortEn;
    logic intTrig;
    logic [1:0] chEn;
    logic rAuto;
    logic [1:0] range;
    logic [1:0][1:0] chMode;
    logic [1:0] hiOff;
    logic [1:0] loOff;
    logic [1:0][31:0] nom;
    logic [1:0][31:0] hiLim;
    logic [1:0][31:0] loLim;
    logic [1:0][31:0] val;
    logic [1:0][31:0] dev;
    logic flagOver;
    logic flagUnder;
    logic accWarn;
    logic [15:0] cnt;
    logic ch;
    logic divInit;
    logic [5:0] bitCnt;
    logic divNeg;
    logic [47:0] quo;
    logic [32:0] rem;
    logic [31:0] den;
    logic pend;
    logic pendWr;
    logic pendMap;
    logic [7:0] pendAddr;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic trigS1;
    logic trigS2;
    logic trigPrev;
    logic measStart;
    logic rangeChg;
    logic [1:0] portOver;
    logic [1:0] portPass;
    logic [1:0] portUnder;
    logic portEnd;
    logic portAccWarn;
  } lcj_regs_t;

  lcj_regs_t r;
  lcj_regs_t n;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function automatic logic [1:0] rangeFlags(logic [31:0] imp, logic [1:0] rg);
    unique case (rg)
      R_1K: rangeFlags = {imp > FLG_HI_1K, imp < FLG_LO_1K};
      R_10K: rangeFlags = {imp > FLG_HI_10K, imp < FLG_LO_10K};
      R_100K: rangeFlags = {imp > FLG_HI_100K, imp < FLG_LO_100K};
      default: rangeFlags = 2'h2;
    endcase
  endfunction

  function automatic logic accOk(logic [31:0] imp, logic [1:0] rg);
    unique case (rg)
      R_1K: accOk = imp >= ACC_LO_1K && imp <= ACC_HI_1K;
      R_10K: accOk = imp >= ACC_LO_10K && imp <= ACC_HI_10K;
      R_100K: accOk = imp >= ACC_LO_100K && imp <= ACC_HI_100K;
      default: accOk = 1'b0;
    endcase
  endfunction

  function automatic logic [1:0] autoPick(logic [31:0] imp);
    if (imp <= ACC_HI_1K) begin
      autoPick = R_1K;
    end else if (imp <= ACC_HI_10K) begin
      autoPick = R_10K;
    end else begin
      autoPick = R_100K;
    end
  endfunction

  function automatic logic [31:0] clampTo(logic [31:0] v, int lim);
    if ($signed(v) > lim) begin
      clampTo = 32'(lim);
    end else if ($signed(v) < -lim) begin
      clampTo = 32'(-lim);
    end else begin
      clampTo = v;
    end
  endfunction

  function automatic logic signed [63:0] thresh(logic [1:0] md, logic [31:0] nomV, logic [31:0] lim);
    logic signed [63:0] n64;
    logic signed [63:0] p64;
    logic signed [63:0] a64;
    n64 = 64'($signed(nomV));
    p64 = 64'($signed(clampTo(lim, PCT_MAX)));
    a64 = (n64 < 0) ? -n64 : n64;
    if (md == LM_PCT) begin
      thresh = n64 + (a64 * p64) / 64'(PCT_SCALE);
    end else if (md == LM_DEV) begin
      thresh = p64;
    end else begin
      thresh = 64'($signed(lim));
    end
  endfunction

  function automatic logic [47:0] devNumer(logic [31:0] a, logic [31:0] b);
    logic signed [32:0] d;
    d = 33'($signed(a)) - 33'($signed(b));
    if (d < 0) begin
      d = -d;
    end
    devNumer = 48'(d) * 48'(PCT_SCALE);
  endfunction

  function automatic logic [31:0] satDev(logic [47:0] mag, logic neg);
    logic [31:0] m;
    m = (mag > 48'(PCT_MAX)) ? 32'(PCT_MAX) : mag[31:0];
    satDev = neg ? -m : m;
  endfunction

  // ----------------------------------------
  // per-channel judgement
  // ----------------------------------------
  logic [1:0][2:0] verdictNow;
  logic [1:0] lowFail;
  logic [1:0] highFail;
  for (genvar i = 0; i < 2; i++) begin : g_judge
    logic signed [63:0] subj;
    assign subj = (r.chMode[i] == LM_DEV) ? 64'($signed(r.dev[i])) : 64'($signed(r.val[i])); // RQ16
    // an off bound never fails; swapped limits are judged as set
    assign lowFail[i] = !r.loOff[i] && subj < thresh(r.chMode[i], r.nom[i], r.loLim[i]); // RQ13 RQ23 RQ10
    assign highFail[i] = !r.hiOff[i] && subj > thresh(r.chMode[i], r.nom[i], r.hiLim[i]); // RQ13 RQ15 RQ10
    always_comb begin
      if (r.flagOver) begin
        verdictNow[i] = V_OVER; // RQ6 RQ22
      end else if (r.flagUnder) begin
        verdictNow[i] = V_UNDER; // RQ6 RQ22
      end else if (lowFail[i]) begin
        verdictNow[i] = V_UNDER; // RQ7
      end else if (highFail[i]) begin
        verdictNow[i] = V_OVER; // RQ8
      end else begin
        verdictNow[i] = V_PASS; // RQ9 RQ5
      end
    end
  end

  logic [32:0] stepTmp;
  logic stepGe;
  assign stepTmp = {r.rem[31:0], r.quo[47]};
  assign stepGe = stepTmp >= {1'b0, r.den};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic adv;
    logic [7:0] idx;
    logic [31:0] rd;
    adv = 1'b0;
    idx = 8'h00;
    rd = 32'h0000_0000;
    n = r;
    n.measStart = 1'b0;
    n.portEnd = 1'b0;
    n.rangeChg = 1'b0;
    n.trigS1 = extTrigN;
    n.trigS2 = r.trigS1;
    n.trigPrev = r.trigS2;
    if (!r.intTrig && r.trigPrev && !r.trigS2) begin
      n.measStart = 1'b1;
    end
    unique case (r.st)
      ST_IDLE: begin
        if (measValid) begin
          n.val[0] = measVal0;
          n.val[1] = measVal1;
          {n.flagOver, n.flagUnder} = rangeFlags(measImp, r.range); // RQ3
          n.accWarn = measUnstable || !accOk(measImp, r.range); // RQ4 RQ20
          n.ch = 1'b0;
          n.divInit = 1'b1;
          n.st = ST_CALC;
          if (r.rAuto && autoPick(measImp) != r.range) begin
            n.range = autoPick(measImp); // RQ1
            n.rangeChg = 1'b1;
            n.cnt = 16'(SETTLE_CYC - 1); // RQ21
            n.st = ST_SETTLE;
          end
        end
      end
      ST_SETTLE: begin
        if (r.cnt == 16'h0000) begin
          n.st = ST_CALC; // RQ21
        end else begin
          n.cnt = r.cnt - 16'h0001;
        end
      end
      ST_CALC: begin
        if (r.divInit) begin
          if (r.chMode[r.ch] == LM_DEV && r.nom[r.ch] != 32'h0000_0000) begin
            n.quo = devNumer(r.val[r.ch], r.nom[r.ch]); // RQ16
            n.rem = 33'h0_0000_0000;
            n.den = ($signed(r.nom[r.ch]) < 0) ? -r.nom[r.ch] : r.nom[r.ch];
            n.divNeg = $signed(r.val[r.ch]) < $signed(r.nom[r.ch]);
            n.bitCnt = 6'h2F;
            n.divInit = 1'b0;
          end else if (r.chMode[r.ch] == LM_DEV && r.val[r.ch] != 32'h0000_0000) begin
            // zero nominal: deviation is unbounded, report the saturated value
            n.dev[r.ch] = satDev(48'hFFFF_FFFF_FFFF, $signed(r.val[r.ch]) < 0); // RQ17
            adv = 1'b1;
          end else begin
            n.dev[r.ch] = 32'h0000_0000;
            adv = 1'b1;
          end
        end else begin
          n.quo = {r.quo[46:0], stepGe};
          n.rem = stepGe ? (stepTmp - {1'b0, r.den}) : stepTmp;
          n.bitCnt = r.bitCnt - 6'h01;
          if (r.bitCnt == 6'h00) begin
            n.dev[r.ch] = satDev({r.quo[46:0], stepGe}, r.divNeg); // RQ17
            adv = 1'b1;
          end
        end
        if (adv) begin
          if (r.ch) begin
            n.st = ST_OUT;
          end else begin
            n.ch = 1'b1;
            n.divInit = 1'b1;
          end
        end
      end
      ST_OUT: begin
        n.st = ST_IDLE;
        if (r.compEn) begin
          for (int i = 0; i < 2; i++) begin
            {n.portOver[i], n.portPass[i], n.portUnder[i]} = r.chEn[i] ? verdictNow[i] : 3'h0; // RQ11 RQ19
          end
          n.portEnd = 1'b1; // RQ19
          n.portAccWarn = r.accWarn; // RQ4
          // keep an external trigger edge that lands in this cycle
          n.measStart = n.measStart || r.intTrig; // RQ19
        end
      end
    endcase
    if (!r.compEn) begin
      n.portOver = 2'h0;
      n.portPass = 2'h0;
      n.portUnder = 2'h0;
      n.portAccWarn = 1'b0;
    end

    // ----------------------------------------
    // AHB-Lite slave: one wait state per transfer
    // ----------------------------------------
    if (r.pend) begin
      n.pend = 1'b0;
      n.hreadyout = 1'b1;
      idx = r.pendAddr - REG_CH0_CFG;
      if (!r.pendMap) begin
        rd = 32'h0000_0000;
      end else if (r.pendAddr >= REG_CH0_CFG && idx < CH_SPAN) begin
        unique case (idx[3:2])
          2'h0: rd = {28'h000_0000, r.loOff[idx[4]], r.hiOff[idx[4]], r.chMode[idx[4]]};
          2'h1: rd = r.nom[idx[4]];
          2'h2: rd = r.hiLim[idx[4]];
          2'h3: rd = r.loLim[idx[4]];
        endcase
        if (r.pendWr) begin
          unique case (idx[3:2])
            2'h0: begin
              n.chMode[idx[4]] = (hwdata[CFG_MODE+:2] == 2'h3) ? LM_FIXED : hwdata[CFG_MODE+:2]; // RQ11
              n.hiOff[idx[4]] = hwdata[CFG_HIOFF]; // RQ15
              n.loOff[idx[4]] = hwdata[CFG_LOOFF]; // RQ23
            end
            2'h1: n.nom[idx[4]] = clampTo(hwdata, VAL_MAX); // RQ12
            2'h2: n.hiLim[idx[4]] = clampTo(hwdata, VAL_MAX); // RQ12 RQ14
            2'h3: n.loLim[idx[4]] = clampTo(hwdata, VAL_MAX); // RQ12 RQ14
          endcase
        end
      end else begin
        case (r.pendAddr)
          REG_CTRL: rd = 32'({r.chEn, r.intTrig, r.sortEn, r.compEn});
          REG_RANGE: rd = 32'({r.range, 1'b0, r.rAuto ? RS_AUTO : RS_HOLD});
          REG_STATUS: rd = 32'({r.st != ST_IDLE, r.portOver[1], r.portPass[1], r.portUnder[1],
                               r.portOver[0], r.portPass[0], r.portUnder[0], r.accWarn, r.flagUnder, r.flagOver});
          REG_REPORT0: rd = (r.chMode[0] == LM_DEV) ? r.dev[0] : r.val[0]; // RQ16
          REG_REPORT1: rd = (r.chMode[1] == LM_DEV) ? r.dev[1] : r.val[1]; // RQ16
          default: rd = 32'h0000_0000;
        endcase
        if (r.pendWr && r.pendAddr == REG_CTRL) begin
          n.compEn = hwdata[CTRL_COMP];
          n.sortEn = hwdata[CTRL_SORT] && !hwdata[CTRL_COMP]; // RQ18
          n.intTrig = hwdata[CTRL_INT];
          n.chEn = hwdata[CTRL_CH0+:2];
          if (hwdata[CTRL_COMP] && !r.compEn && hwdata[CTRL_INT]) begin
            n.measStart = 1'b1; // RQ19
          end
        end
        if (r.pendWr && r.pendAddr == REG_RANGE) begin
          unique case (hwdata[2:0])
            RS_AUTO: n.rAuto = 1'b1; // RQ1
            RS_HOLD: n.rAuto = 1'b0; // RQ2
            RS_1K: {n.rAuto, n.range} = {1'b0, R_1K}; // RQ2
            RS_10K: {n.rAuto, n.range} = {1'b0, R_10K}; // RQ2
            RS_100K: {n.rAuto, n.range} = {1'b0, R_100K}; // RQ2
            default: n.rAuto = r.rAuto;
          endcase
        end
      end
      n.hrdata = r.pendWr ? r.hrdata : rd;
    end else if (hsel && hready && htrans[1]) begin
      n.pend = 1'b1;
      n.pendWr = hwrite;
      n.pendAddr = haddr[7:0];
      n.pendMap = haddr[31:8] == 24'h00_0000 && haddr[1:0] == 2'h0 && hsize == 3'h2;
      n.hreadyout = 1'b0;
    end

    if (rst) begin
      n = '0;
      {n.chEn, n.intTrig, n.sortEn, n.compEn} = CTRL_RST[4:0];
      n.rAuto = 1'b1;
      n.hreadyout = 1'b1;
      n.trigS1 = 1'b1;
      n.trigS2 = 1'b1;
      n.trigPrev = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign hreadyout = r.hreadyout;
  assign hrdata = r.hrdata;
  assign hresp = r.hresp;
  assign measStart = r.measStart;
  assign rangeSel = r.range;
  assign rangeChanged = r.rangeChg;
  assign sortActive = r.sortEn;
  assign portOver = r.portOver;
  assign portPass = r.portPass;
  assign portUnder = r.portUnder;
  assign portEnd = r.portEnd;
  assign portAccWarn = r.portAccWarn;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  localparam int DEV_LIM = 99999;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_auto_pick: assert property (r.st == ST_IDLE && measValid && r.rAuto |=> r.range == autoPick($past(measImp))) // RQ1
    else $error("auto range pick wrong");
  chk_range_held: assert property (!r.rAuto && !(r.pend && r.pendWr && r.pendAddr == REG_RANGE) |=> $stable(r.range)) // RQ2
    else $error("fixed range moved");
  chk_acc_warn: assert property (r.st == ST_IDLE && measValid && measUnstable |=> r.accWarn) // RQ4
    else $error("accuracy warning missing");
  chk_verdict_onehot: assert property ($onehot0({portOver[0], portPass[0], portUnder[0]})
    && $onehot0({portOver[1], portPass[1], portUnder[1]})) // RQ5
    else $error("verdict not one-hot");
  chk_force_over: assert property (r.st == ST_OUT && r.compEn && r.chEn[0] && r.flagOver |=> portOver[0]) // RQ6
    else $error("range over not forced");
  chk_low_fail: assert property (r.st == ST_OUT && r.compEn && r.chEn[0] && !r.flagOver && !r.flagUnder
    && lowFail[0] |=> portUnder[0] ##1 portUnder[0]) // RQ7
    else $error("lower check fail not under");
  chk_high_fail: assert property (r.st == ST_OUT && r.compEn && r.chEn[1] && !r.flagOver && !r.flagUnder
    && !lowFail[1] && highFail[1] |=> portOver[1]) // RQ8
    else $error("upper check fail not over");
  chk_pass_both: assert property ($rose(portPass[0]) |-> $past(!lowFail[0] && !highFail[0] && !r.flagOver)) // RQ9
    else $error("pass without both checks");
  chk_dev_sat: assert property ($signed(r.dev[0]) <= DEV_LIM && $signed(r.dev[0]) >= -DEV_LIM) // RQ17
    else $error("deviation not saturated");
  chk_mode_excl: assert property (!(r.compEn && r.sortEn)) // RQ18
    else $error("comparator and sorting both on");
  chk_int_start: assert property (r.st == ST_OUT && r.compEn && r.intTrig |=> measStart && portEnd) // RQ19
    else $error("internal trigger restart missing");
  chk_settle_time: assert property ($rose(r.st == ST_SETTLE) |-> r.cnt == 16'(SETTLE_CYC - 1) && rangeChanged) // RQ21
    else $error("settle delay wrong");
  chk_bus_wait: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state wrong");

  cov_pass: cover property (portEnd && portPass[0]);
  cov_over: cover property (portEnd && portOver[0]);
  cov_under: cover property (portEnd && portUnder[1]);
  cov_range_switch: cover property (r.st == ST_SETTLE ##[1:600] portEnd);
endmodule

// File: verification/lcj_engine_model.sv
// Purpose: behavioural measurement engine facing the range judge
// Assumes: one result per measStart, DLY cycles later
// Notes: data lines show the inverse of the result outside the strobe
module lcj_engine_model #(
  parameter int DLY = 3
) (
  clk, // system clock
  rst, // synchronous reset
  measStart, // request from the judge
  imp, // impedance to report
  v0, // channel 0 value
  v1, // channel 1 value
  uns, // report unstable
  measValid, // result strobe
  measImp, // impedance
  measVal0, // channel 0 value out
  measVal1, // channel 1 value out
  measUnstable // unstable flag out
);
  timeunit 1ns;
  timeprecision 100ps;
  input wire logic clk;
  input wire logic rst;
  input wire logic measStart;
  input wire logic [31:0] imp;
  input wire logic [31:0] v0;
  input wire logic [31:0] v1;
  input wire logic uns;
  output logic measValid;
  output logic [31:0] measImp;
  output logic [31:0] measVal0;
  output logic [31:0] measVal1;
  output logic measUnstable;
  int cnt;
  always @(posedge clk) begin
    measValid <= 1'b0;
    {measImp, measVal0, measVal1, measUnstable} <= ~{imp, v0, v1, uns};
    if (rst) begin
      cnt <= 0;
    end else if (measStart) begin
      cnt <= DLY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    if (!rst && cnt == 1) begin
      measValid <= 1'b1;
      {measImp, measVal0, measVal1, measUnstable} <= {imp, v0, v1, uns};
    end
  end
endmodule

// File: verification/tb_top.sv
// Purpose: self-checking bench of the range judge and limit comparator
// Assumes: one slave on the bus, engine model on the far side
// Notes: settle count shortened to 4 cycles
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("FAIL %s exp %0h got %0h", n, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lcj_pkg::*;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, extTrigN = 1, uns = 0, measValid, measUnstable;
  logic [31:0] haddr = 0, hwdata = 0, imp = 0, v0 = 0, v1 = 0, measImp, measVal0, measVal1, rdat;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, measStart, rangeChanged, sortActive, portEnd, portAccWarn;
  logic [31:0] hrdata;
  logic [1:0] rangeSel, portOver, portPass, portUnder;
  int errors = 0, check_count = 0;
  int rngSw = 0, starts = 0;
  wire [2:0] vd0 = {portOver[0], portPass[0], portUnder[0]};
  wire [2:0] vd1 = {portOver[1], portPass[1], portUnder[1]};
  lcj_range_judge #(.SETTLE_CYC(4)) dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .measValid(measValid), .measImp(measImp), .measVal0(measVal0),
    .measVal1(measVal1), .measUnstable(measUnstable), .extTrigN(extTrigN), .measStart(measStart),
    .rangeSel(rangeSel), .rangeChanged(rangeChanged), .sortActive(sortActive), .portOver(portOver),
    .portPass(portPass), .portUnder(portUnder), .portEnd(portEnd), .portAccWarn(portAccWarn));
  lcj_engine_model eng (.clk(clk), .rst(rst), .measStart(measStart), .imp(imp), .v0(v0), .v1(v1),
    .uns(uns), .measValid(measValid), .measImp(measImp), .measVal0(measVal0), .measVal1(measVal1),
    .measUnstable(measUnstable));
  initial begin
    forever #2 clk = ~clk;
  end
  // count one-cycle pulses so that tasks can judge them afterwards
  always @(posedge clk) begin
    rngSw <= rngSw + int'(rangeChanged === 1'b1);
    starts <= starts + int'(measStart === 1'b1);
  end
  // --------------------------------
  // bus and measurement helpers
  // --------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wend;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (portEnd !== 1'b1 && n < 3000);
    `CHK("portEnd", 1'b1, portEnd)
    @(posedge clk);
  endtask
  task automatic meas(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b, input logic u);
    {imp, v0, v1, uns} <= {i, a, b, u};
    @(posedge clk);
    extTrigN <= 1'b0;
    repeat (3) @(posedge clk);
    extTrigN <= 1'b1;
    wend();
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset;
    `CHK("sortActive", 1'b0, sortActive)
    `CHK("hresp", 1'b0, hresp)
    `CHK("portPass", 2'h0, portPass)
    rd(REG_CTRL);
    `CHK("ctrl", CTRL_RST, rdat)
    rd(8'h40);
    `CHK("unmapped", 32'h0, rdat)
    $display("test reset done");
  endtask
  task automatic t_fixed;
    wr(REG_RANGE, 32'h2);
    rd(REG_RANGE);
    `CHK("range", 32'h1, rdat)
    wr(8'h1C, 32'h7FFF_FFFF);
    rd(8'h1C);
    `CHK("clamp", 32'h0BEB_C200, rdat)
    wr(8'h1C, 32'h64);
    wr(8'h20, 32'hFFFF_FF9C);
    wr(8'h2C, 32'hFFFF_FFF6);
    wr(8'h30, 32'hA);
    wr(REG_CTRL, 32'h19);
    meas(32'd1000, 32'd100, 32'd0, 1'b0);
    `CHK("ch0 eq", V_PASS, vd0)
    `CHK("ch1 swap", V_UNDER, vd1)
    `CHK("acc", 1'b0, portAccWarn)
    meas(32'd1000, 32'd101, 32'd0, 1'b0);
    `CHK("ch0 over", V_OVER, vd0)
    meas(32'd1000, 32'hFFFF_FF9B, 32'd0, 1'b0);
    `CHK("ch0 under", V_UNDER, vd0)
    `CHK("starts", 3, starts)
    $display("test fixed done");
  endtask
  task automatic t_range;
    meas(32'd5, 32'd0, 32'd0, 1'b0);
    `CHK("under rng", {V_UNDER, V_UNDER}, {vd0, vd1})
    `CHK("acc low", 1'b1, portAccWarn)
    meas(32'd4000000, 32'd0, 32'd20, 1'b0);
    `CHK("over rng", {V_OVER, V_OVER}, {vd0, vd1})
    `CHK("held", R_1K, rangeSel)
    meas(32'd1000, 32'd0, 32'd20, 1'b1);
    `CHK("unstable", 1'b1, portAccWarn)
    `CHK("ch0 in", V_PASS, vd0)
    `CHK("ch1 over", V_OVER, vd1)
    $display("test range done");
  endtask
  task automatic t_pct;
    wr(8'h14, 32'h9);
    wr(8'h18, 32'd1000);
    wr(8'h1C, 32'd1000);
    wr(8'h24, 32'h4);
    meas(32'd1000, 32'd1101, 32'd999999, 1'b0);
    `CHK("pct over", V_OVER, vd0)
    `CHK("up off", V_PASS, vd1)
    meas(32'd1000, 32'hFFFF_EC78, 32'd999999, 1'b0);
    `CHK("lo off", V_PASS, vd0)
    wr(8'h1C, 32'd200000);
    meas(32'd1000, 32'd11000, 32'd999999, 1'b0);
    `CHK("pct clamp", V_OVER, vd0)
    $display("test percent done");
  endtask
  task automatic t_dev;
    wr(8'h14, 32'h2);
    wr(8'h1C, 32'd500);
    wr(8'h20, 32'hFFFF_FE0C);
    meas(32'd1000, 32'd1051, 32'd999999, 1'b0);
    `CHK("dev over", V_OVER, vd0)
    rd(REG_REPORT0);
    `CHK("dev val", 32'd510, rdat)
    meas(32'd1000, 32'h0BEB_C200, 32'd999999, 1'b0);
    rd(REG_REPORT0);
    `CHK("dev max", 32'd99999, rdat)
    meas(32'd1000, 32'hF414_3E00, 32'd999999, 1'b0);
    `CHK("dev under", V_UNDER, vd0)
    rd(REG_REPORT0);
    `CHK("dev min", 32'hFFFE_7961, rdat)
    $display("test deviation done");
  endtask
  task automatic t_auto;
    wr(REG_RANGE, 32'h0);
    meas(32'd5000000, 32'd1000, 32'd999999, 1'b0);
    `CHK("auto sel", R_10K, rangeSel)
    `CHK("range switch", 1, rngSw)
    rd(REG_RANGE);
    `CHK("auto rd", 32'h10, rdat)
    wr(REG_RANGE, 32'h4);
    rd(REG_RANGE);
    `CHK("pick 100k", 32'h21, rdat)
    $display("test auto done");
  endtask
  task automatic t_int;
    {imp, v0} <= {32'd1000, 32'd1000};
    // comparator must go off first: only entering comparator mode starts the internal trigger
    wr(REG_CTRL, 32'h18);
    wr(REG_CTRL, 32'h1D);
    wend();
    `CHK("int verdict", V_UNDER, vd0)
    wr(REG_CTRL, 32'h3);
    `CHK("sort off", 1'b0, sortActive)
    wr(REG_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    `CHK("sort on", 1'b1, sortActive)
    `CHK("ports off", 2'h0, portPass | portOver | portUnder)
    $display("test trigger done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_fixed();
    t_range();
    t_pct();
    t_dev();
    t_auto();
    t_int();
    print_verdict();
  end
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule
